//--- core/ext_irq_pkg.sv
package ext_irq_pkg;

  // ==========================================================================
  // special-function addresses and reset values
  localparam logic [7:0] XCTL_ADDR       = 8'hC0;
  localparam logic [7:0] PORT_ADDR       = 8'hD8;
  localparam logic [7:0] XCTL_RESET      = 8'h00;
  localparam logic [3:0] PORT_RESET      = 4'hF;
  // upper nibble of the auxiliary port is not built and reads as ones
  localparam logic [3:0] PORT_UNUSED     = 4'hF;
  localparam logic [7:0] UNMAPPED_READ   = 8'h00;

  // ==========================================================================
  // sources, pins and vectors
  localparam int         NUM_SRC         = 8;
  localparam logic [2:0] SRC_C           = 3'h6;
  localparam logic [2:0] SRC_D           = 3'h7;
  localparam int         PIN_C           = 2;
  localparam int         PIN_D           = 3;
  localparam logic [7:0] VECTOR_BASE     = 8'h03;
  localparam int         PORT_BITS       = 4;
  localparam logic       PIN_IDLE        = 1'b1;

  // ==========================================================================
  // control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic prio_high;
    logic enable;
    logic pending;
    logic edge_select;
  } irq_ctl_t;

  typedef struct packed {
    irq_ctl_t irq_d;
    irq_ctl_t irq_c;
  } xctl_t;

  // special-function access from the core: byte access and bit access
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] bit_addr;
    logic       bit_val;
    logic       bit_wr;
  } sfr_req_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_OFFER = 3'b010,
    ST_SERVE = 3'b100
  } arb_state_t;

endpackage : ext_irq_pkg

//--- core/ext_irq_channel.sv
`timescale 1ns/1ps
`default_nettype none

module ext_irq_channel (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic pin_level,
  input  wire logic edge_select,
  input  wire logic sw_wr,
  input  wire logic sw_val,
  input  wire logic serviced,
  output logic      pending
);

  logic prev_q;
  logic pending_q;
  logic fall;

  assign fall    = prev_q & ~pin_level;
  assign pending = pending_q;

  // ==========================================================================
  // pin history for falling-edge detection
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev_q <= ext_irq_pkg::PIN_IDLE;
    end else begin
      prev_q <= pin_level;
    end
  end

  // ==========================================================================
  // pending flag
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pending_q <= 1'b0;
    end else if (!edge_select) begin
      // level mode is not latched: the flag mirrors a low pin
      pending_q <= ~pin_level;
    end else if (fall) begin
      // a new edge beats a clear in the same cycle
      pending_q <= 1'b1;
    end else if (serviced) begin
      pending_q <= 1'b0;
    end else if (sw_wr) begin
      pending_q <= sw_val;
    end
  end

endmodule : ext_irq_channel

`default_nettype wire

//--- core/ext_irq_port4.sv
// What this block does
// - Control register lives at special address C0H, each bit settable alone.
// - Bit set at bit address C2H sets the third interrupt's enable, bit 2.
// - Priority bit set means high priority, clear means low priority.
// - An added interrupt requests service only while its enable bit is set.
// - Type bit set selects falling edge, clear selects low level.
// - Edge mode: falling edge sets pending, vectoring to service clears it.
// - Eight sources vector from 03H to 3BH in steps of eight.
// - Equal-level ties resolve by fixed order, source 0 first, 7 last.
// - Third interrupt: enable is bit 2, trigger type is bit 0.
// - Auxiliary port at D8H, bit-addressable, only low four bits built.
// - Port bits 2 and 3 double as the two added interrupt pins.
// - Port write drives the pins; port read returns pin state.
// - Added interrupts handle priority, enable, type, pending like originals.
// - Each port pin is bidirectional with an internal pull-up.
// - Reset sets port latch to FFH and control register to 00H.
`timescale 1ns/1ps
`default_nettype none

module ext_irq_port4 (
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire ext_irq_pkg::sfr_req_t sfr_req,
  output logic [7:0]                sfr_rdata,
  input  wire logic [5:0]           core_req,
  input  wire logic [5:0]           core_high,
  input  wire logic                 irq_ack,
  input  wire logic [3:0]           port_in,
  output logic [3:0]                port_out,
  output logic [3:0]                port_oe,
  output logic                      irq_req,
  output logic [7:0]                irq_vector,
  output logic [2:0]                irq_source,
  output logic                      irq_high
);

  // ==========================================================================
  // helpers
  function automatic logic [2:0] first_set(input logic [7:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = ext_irq_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction : first_set

  function automatic logic [7:0] vector_of(input logic [2:0] idx);
    return ext_irq_pkg::VECTOR_BASE + {2'b00, idx, 3'b000};
  endfunction : vector_of

  function automatic logic [7:0] put_bit(input logic [7:0] cur,
                                         input logic [2:0] idx,
                                         input logic       val);
    logic [7:0] res;
    res      = cur;
    res[idx] = val;
    return res;
  endfunction : put_bit

  // ==========================================================================
  // state
  ext_irq_pkg::xctl_t       xctl_q;
  ext_irq_pkg::xctl_t       xctl_rd;
  logic [7:0]               xctl_d;
  ext_irq_pkg::xctl_t       xctl_wr;
  logic                     xctl_we;
  logic [3:0]               latch_q;
  logic [3:0]               latch_d;
  logic [3:0]               sync1_q;
  logic [3:0]               sync2_q;
  logic [3:0]               sync3_q;
  logic [3:0]               filt_q;
  logic                     pend_c;
  logic                     pend_d;
  logic                     svc_c;
  logic                     svc_d;
  logic [7:0]               req_all;
  logic [7:0]               high_all;
  logic [7:0]               req_high;
  logic [7:0]               req_low;
  logic                     any_req;
  logic                     pick_high;
  logic [2:0]               pick;
  ext_irq_pkg::arb_state_t  state_q;
  logic [7:0]               rdata_q;
  logic [3:0]               port_out_q;
  logic [3:0]               port_oe_q;
  logic                     irq_req_q;
  logic [7:0]               irq_vector_q;
  logic [2:0]               irq_source_q;
  logic                     irq_high_q;

  logic xctl_bit_hit;
  logic port_bit_hit;

  assign sfr_rdata  = rdata_q;
  assign port_out   = port_out_q;
  assign port_oe    = port_oe_q;
  assign irq_req    = irq_req_q;
  assign irq_vector = irq_vector_q;
  assign irq_source = irq_source_q;
  assign irq_high   = irq_high_q;
  // typed view of the next control value; in edge mode the channels take
  // their pending bits from it on a control write unless an edge or a service wins
  assign xctl_wr    = xctl_d;

  // ==========================================================================
  // pin input filter: a change counts once stages two and three agree;
  // the extra stage costs a cycle of latency but keeps a pin that moves
  // near the clock edge from reaching the edge detector half settled
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= ext_irq_pkg::PORT_RESET;
      sync2_q <= ext_irq_pkg::PORT_RESET;
      sync3_q <= ext_irq_pkg::PORT_RESET;
      filt_q  <= ext_irq_pkg::PORT_RESET;
    end else begin
      sync1_q <= port_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      for (int i = 0; i < ext_irq_pkg::PORT_BITS; i++) begin
        if (sync2_q[i] == sync3_q[i]) begin
          filt_q[i] <= sync3_q[i];
        end
      end
    end
  end

  // ==========================================================================
  // register decode; bit address upper five bits select the register
  assign xctl_bit_hit = sfr_req.bit_wr &&
      (sfr_req.bit_addr[7:3] == ext_irq_pkg::XCTL_ADDR[7:3]);
  assign port_bit_hit = sfr_req.bit_wr &&
      (sfr_req.bit_addr[7:3] == ext_irq_pkg::PORT_ADDR[7:3]);

  always_comb begin
    xctl_rd                = xctl_q;
    xctl_rd.irq_c.pending  = pend_c;
    xctl_rd.irq_d.pending  = pend_d;
  end

  always_comb begin
    xctl_we = 1'b0;
    xctl_d  = xctl_rd;
    if (sfr_req.wr && sfr_req.addr == ext_irq_pkg::XCTL_ADDR) begin
      xctl_we = 1'b1;
      xctl_d  = sfr_req.wdata;
    end else if (xctl_bit_hit) begin
      xctl_we = 1'b1;
      xctl_d  = put_bit(xctl_rd, sfr_req.bit_addr[2:0],
                        sfr_req.bit_val);
    end
  end

  always_comb begin
    latch_d = latch_q;
    if (sfr_req.wr && sfr_req.addr == ext_irq_pkg::PORT_ADDR) begin
      latch_d = sfr_req.wdata[3:0];
    end else if (port_bit_hit && !sfr_req.bit_addr[2]) begin
      latch_d[sfr_req.bit_addr[1:0]] = sfr_req.bit_val;
    end
  end

  // ==========================================================================
  // control register; pending bits live in the channels
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      xctl_q <= ext_irq_pkg::XCTL_RESET;
    end else if (xctl_we) begin
      xctl_q <= xctl_d;
    end
  end

  // ==========================================================================
  // auxiliary port: drives low hard, leaves high to the pull-up
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      latch_q    <= ext_irq_pkg::PORT_RESET;
      port_out_q <= ext_irq_pkg::PORT_RESET;
      port_oe_q  <= 4'h0;
    end else begin
      latch_q    <= latch_d;
      port_out_q <= latch_d;
      port_oe_q  <= ~latch_d;
    end
  end

  // ==========================================================================
  // read data, held until the next read
  // an unmapped address reads as zero rather than stale data
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= ext_irq_pkg::UNMAPPED_READ;
    end else if (sfr_req.rd) begin
      case (sfr_req.addr)
        ext_irq_pkg::XCTL_ADDR: rdata_q <= xctl_rd;
        ext_irq_pkg::PORT_ADDR: begin
          rdata_q <= {ext_irq_pkg::PORT_UNUSED, filt_q};
        end
        default:                rdata_q <= ext_irq_pkg::UNMAPPED_READ;
      endcase
    end
  end

  // ==========================================================================
  // added interrupt channels; pins must be left high in the latch to be used,
  // since a latch bit of zero pulls the pin low and reads as a level request
  ext_irq_channel u_irq_c (
    .clk         (clk),
    .rstn        (rstn),
    .pin_level   (filt_q[ext_irq_pkg::PIN_C]),
    .edge_select (xctl_q.irq_c.edge_select),
    .sw_wr       (xctl_we),
    .sw_val      (xctl_wr.irq_c.pending),
    .serviced    (svc_c),
    .pending     (pend_c)
  );

  ext_irq_channel u_irq_d (
    .clk         (clk),
    .rstn        (rstn),
    .pin_level   (filt_q[ext_irq_pkg::PIN_D]),
    .edge_select (xctl_q.irq_d.edge_select),
    .sw_wr       (xctl_we),
    .sw_val      (xctl_wr.irq_d.pending),
    .serviced    (svc_d),
    .pending     (pend_d)
  );

  // ==========================================================================
  // arbitration: high level first, then fixed order inside a level;
  // sources 0..5 arrive already enabled; only the added two are gated here
  assign req_all  = {xctl_q.irq_d.enable & pend_d,
                     xctl_q.irq_c.enable & pend_c,
                     core_req};
  assign high_all = {xctl_q.irq_d.prio_high,
                     xctl_q.irq_c.prio_high,
                     core_high};
  assign req_high  = req_all & high_all;
  assign req_low   = req_all & ~high_all;
  assign any_req   = |req_all;
  assign pick_high = |req_high;
  assign pick      = pick_high ? first_set(req_high) : first_set(req_low);

  // service clears only bite in edge mode; level flags follow the pin
  assign svc_c = (state_q == ext_irq_pkg::ST_OFFER) && irq_ack &&
                 (irq_source_q == ext_irq_pkg::SRC_C);
  assign svc_d = (state_q == ext_irq_pkg::ST_OFFER) && irq_ack &&
                 (irq_source_q == ext_irq_pkg::SRC_D);

  // ==========================================================================
  // request offer; the serve cycle lets a cleared flag settle before the
  // next pick, so one edge is never vectored twice
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q      <= ext_irq_pkg::ST_IDLE;
      irq_req_q    <= 1'b0;
      irq_vector_q <= ext_irq_pkg::VECTOR_BASE;
      irq_source_q <= 3'h0;
      irq_high_q   <= 1'b0;
    end else begin
      case (state_q)
        ext_irq_pkg::ST_IDLE: begin
          if (any_req) begin
            state_q      <= ext_irq_pkg::ST_OFFER;
            irq_req_q    <= 1'b1;
            irq_vector_q <= vector_of(pick);
            irq_source_q <= pick;
            irq_high_q   <= pick_high;
          end
        end
        ext_irq_pkg::ST_OFFER: begin
          if (irq_ack) begin
            state_q   <= ext_irq_pkg::ST_SERVE;
            irq_req_q <= 1'b0;
          end else if (!any_req) begin
            state_q   <= ext_irq_pkg::ST_IDLE;
            irq_req_q <= 1'b0;
          end else begin
            irq_vector_q <= vector_of(pick);
            irq_source_q <= pick;
            irq_high_q   <= pick_high;
          end
        end
        ext_irq_pkg::ST_SERVE: begin
          state_q <= ext_irq_pkg::ST_IDLE;
        end
        default: begin
          state_q   <= ext_irq_pkg::ST_IDLE;
          irq_req_q <= 1'b0;
        end
      endcase
    end
  end

endmodule : ext_irq_port4

`default_nettype wire

//--- verification/ext_irq_port4_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module ext_irq_chk (
  input wire logic                  clk,
  input wire logic                  rstn,
  input wire ext_irq_pkg::sfr_req_t sfr_req,
  input wire logic [7:0]            sfr_rdata,
  input wire logic [5:0]            core_req,
  input wire logic [5:0]            core_high,
  input wire logic                  irq_ack,
  input wire logic [3:0]            port_out,
  input wire logic [3:0]            port_oe,
  input wire logic                  irq_req,
  input wire logic [7:0]            irq_vector,
  input wire logic [2:0]            irq_source,
  input wire logic                  irq_high
);
  // ==========================================================================
  // offer and register checks
  logic [7:0] low_mask;
  assign low_mask = (8'h01 << irq_source) - 8'h01;

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  a_vector_map: assert property (irq_req |->
    irq_vector == 8'h03 + {2'h0, irq_source, 3'h0})
    else $error("vector does not match source");
  a_pullup_drive: assert property (port_oe == ~port_out)
    else $error("pin driven where latch is one");
  a_ack_drop: assert property (irq_req && irq_ack |=> !irq_req)
    else $error("offer kept after ack");
  a_port_write: assert property (sfr_req.wr && sfr_req.addr == 8'hD8
    |=> port_out == $past(sfr_req.wdata[3:0]))
    else $error("port write not on pins");
  a_top_nibble: assert property (sfr_req.rd && sfr_req.addr == 8'hD8
    |=> sfr_rdata[7:4] == 4'hF)
    else $error("unbuilt port bits not ones");
  a_unmapped_read: assert property (sfr_req.rd
    && sfr_req.addr != 8'hD8
    && sfr_req.addr != 8'hC0 |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_high_wins: assert property (irq_req && !irq_high |->
    $past(core_req & core_high) == 6'h00)
    else $error("low offer over high request");
  a_poll_order: assert property (irq_req |-> ((irq_high ?
    $past(core_req & core_high) : $past(core_req & ~core_high))
    & low_mask[5:0]) == 6'h00)
    else $error("lower index of same level skipped");
endmodule : ext_irq_chk

bind ext_irq_port4 ext_irq_chk u_chk (.clk(clk), .rstn(rstn),
  .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .core_req(core_req),
  .core_high(core_high), .irq_ack(irq_ack), .port_out(port_out),
  .port_oe(port_oe), .irq_req(irq_req), .irq_vector(irq_vector),
  .irq_source(irq_source), .irq_high(irq_high));

`default_nettype wire

//--- verification/ext_src_model.sv
`timescale 1ns/1ps
`default_nettype none

module ext_src_model (
  input  wire logic [3:0] port_out,
  input  wire logic [3:0] port_oe,
  input  wire logic [3:0] drv_en,
  input  wire logic [3:0] drv_val,
  output logic      [3:0] pin
);
  // ==========================================================================
  // pin resolution: undriven pins float up to the pull-up level
  assign pin = (port_oe & port_out)
             | (~port_oe & ((drv_en & drv_val) | ~drv_en));
endmodule : ext_src_model

`default_nettype wire

//--- verification/ext_irq_port4_ext_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module ext_irq_port4_ext_tb_top;
  logic                  clk       = 1'b0;
  logic                  rstn      = 1'b0;
  ext_irq_pkg::sfr_req_t req       = '0;
  logic [5:0]            core_req  = 6'h00;
  logic [5:0]            core_high = 6'h00;
  logic                  irq_ack   = 1'b0;
  logic [3:0]            drv_en    = 4'h0;
  logic [3:0]            drv_val   = 4'hF;
  logic [7:0]            rdata;
  logic [7:0]            irq_vector;
  logic [3:0]            pins;
  logic [3:0]            port_out;
  logic [3:0]            port_oe;
  logic                  irq_req;
  logic                  irq_high;
  logic [2:0]            irq_source;
  int                    err_total = 0;
  int                    tests_run = 0;

  always #10 clk = ~clk;

  ext_irq_port4 DUT (.clk(clk), .rstn(rstn), .sfr_req(req),
    .sfr_rdata(rdata), .core_req(core_req), .core_high(core_high),
    .irq_ack(irq_ack), .port_in(pins), .port_out(port_out),
    .port_oe(port_oe), .irq_req(irq_req), .irq_vector(irq_vector),
    .irq_source(irq_source), .irq_high(irq_high));
  ext_src_model u_src (.port_out(port_out), .port_oe(port_oe),
    .drv_en(drv_en), .drv_val(drv_val), .pin(pins));

  // ==========================================================================
  // shared bus and compare tasks, entered and left at a rising edge
  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic bwr(input logic [7:0] a, input logic v);
    req.bit_addr <= a;
    req.bit_val <= v;
    req.bit_wr <= 1'b1;
    @(posedge clk);
    req.bit_wr <= 1'b0;
    @(posedge clk);
  endtask : bwr

  // rdata holds until the next read, so it is safe at the second edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask : rd

  task automatic ack_it;
    irq_ack <= 1'b1;
    @(posedge clk);
    irq_ack <= 1'b0;
    @(posedge clk);
    chk("ack drop", 8'h00, {7'h0, irq_req});
  endtask : ack_it

  task automatic wait_req(input logic e);
    int n;
    n = 0;
    while (irq_req !== e && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk("irq_req", {7'h0, e}, {7'h0, irq_req});
  endtask : wait_req

  // ==========================================================================
  // scenarios
  task automatic t_reset;
    logic [7:0] d;
    chk("port_out", 8'h0F, {4'h0, port_out});
    chk("port_oe", 8'h00, {4'h0, port_oe});
    rd(8'hC0, d);
    chk("ctl", 8'h00, d);
    rd(8'hD8, d);
    chk("port", 8'hFF, d);
    rd(8'h80, d);
    chk("unmapped", 8'h00, d);
  endtask : t_reset

  // the low pin 2 is a level request too; it must settle before t_bits
  task automatic t_port;
    logic [7:0] d;
    wr(8'hD8, 8'h0A);
    chk("port_out", 8'h0A, {4'h0, port_out});
    chk("port_oe", 8'h05, {4'h0, port_oe});
    repeat (4) @(posedge clk);
    rd(8'hD8, d);
    chk("port rd", 8'hFA, d);
    rd(8'hC0, d);
    chk("pin 2 level", 8'h02, d);
    bwr(8'hD8, 1'b1);
    chk("port bit", 8'h0B, {4'h0, port_out});
    bwr(8'hDC, 1'b0);
    chk("port bit DC", 8'h0B, {4'h0, port_out});
    wr(8'hD8, 8'h0F);
    repeat (6) @(posedge clk);
  endtask : t_port

  // pending bits 1 and 5 are left out so that no request is raised
  task automatic t_bits;
    logic [7:0] d;
    logic [7:0] e;
    e = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (i == 1 || i == 5) continue;
      e[i] = 1'b1;
      bwr(8'hC0 + 8'(i), 1'b1);
      rd(8'hC0, d);
      chk("ctl bit set", e, d);
    end
    bwr(8'hC2, 1'b0);
    rd(8'hC0, d);
    chk("ctl bit clr", 8'hD9, d);
    wr(8'hC0, 8'h00);
    bwr(8'hC2, 1'b1);
    rd(8'hC0, d);
    chk("ctl C2", 8'h04, d);
    wr(8'hC0, 8'h00);
  endtask : t_bits

  task automatic t_edge;
    logic [7:0] d;
    wr(8'hC0, 8'h05);
    drv_en <= 4'h4;
    drv_val <= 4'hB;
    wait_req(1'b1);
    chk("vector", 8'h33, irq_vector);
    chk("source", 8'h06, {5'h0, irq_source});
    rd(8'hC0, d);
    chk("pending", 8'h07, d);
    ack_it();
    rd(8'hC0, d);
    chk("pending clr", 8'h05, d);
    drv_val <= 4'hF;
    repeat (6) @(posedge clk);
    drv_val <= 4'hB;
    wait_req(1'b1);
    ack_it();
    drv_en <= 4'h0;
    wr(8'hC0, 8'h00);
  endtask : t_edge

  task automatic t_level;
    logic [7:0] d;
    drv_en <= 4'h8;
    drv_val <= 4'h7;
    repeat (8) @(posedge clk);
    chk("disabled", 8'h00, {7'h0, irq_req});
    rd(8'hC0, d);
    chk("level pend", 8'h20, d);
    wr(8'hC0, 8'hC0);
    wait_req(1'b1);
    chk("vector", 8'h3B, irq_vector);
    chk("high", 8'h01, {7'h0, irq_high});
    core_req <= 6'h01;
    repeat (3) @(posedge clk);
    chk("high src", 8'h07, {5'h0, irq_source});
    core_req <= 6'h00;
    drv_val <= 4'hF;
    wait_req(1'b0);
    drv_en <= 4'h0;
    wr(8'hC0, 8'h00);
  endtask : t_level

  // both added pins fall together: level c polls ahead of edge d, and the
  // latched edge of d is offered once c lets go, and only once
  task automatic t_pair;
    logic [7:0] d;
    wr(8'hC0, 8'h54);
    drv_en <= 4'hC;
    drv_val <= 4'h3;
    wait_req(1'b1);
    chk("pair src", 8'h06, {5'h0, irq_source});
    rd(8'hC0, d);
    chk("pair pend", 8'h76, d);
    drv_val <= 4'h7;
    repeat (8) @(posedge clk);
    chk("edge src", 8'h07, {5'h0, irq_source});
    chk("edge vec", 8'h3B, irq_vector);
    ack_it();
    rd(8'hC0, d);
    chk("edge clr", 8'h54, d);
    chk("no rearm", 8'h00, {7'h0, irq_req});
    drv_en <= 4'h0;
    wr(8'hC0, 8'h00);
  endtask : t_pair

  task automatic t_order;
    for (int i = 0; i < 6; i++) begin
      core_req <= 6'(6'h3F << i);
      wait_req(1'b1);
      chk("source", 8'(i), {5'h0, irq_source});
      chk("vector", 8'h03 + 8'(i * 8), irq_vector);
      core_req <= 6'h00;
      ack_it();
    end
    core_high <= 6'h20;
    core_req <= 6'h3F;
    wait_req(1'b1);
    chk("high src", 8'h05, {5'h0, irq_source});
    core_req <= 6'h00;
    ack_it();
    core_high <= 6'h00;
  endtask : t_order

  task automatic end_sim;
    if (err_total == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_port();
    t_bits();
    t_edge();
    t_level();
    t_pair();
    t_order();
    end_sim();
  end

  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    end_sim();
  end
endmodule : ext_irq_port4_ext_tb_top

`default_nettype wire
